// [rtl/urx_pkg.sv]
// constants and register map of the serial receive and baud block
package urx_pkg;
    // register byte addresses
    localparam logic [7:0] OFS_STAT1    = 8'h10;
    localparam logic [7:0] OFS_STAT2    = 8'h14;
    localparam logic [7:0] OFS_DATA     = 8'h18;
    localparam logic [7:0] OFS_RATE     = 8'h1C;
    localparam logic [7:0] OFS_CTRL3    = 8'h20;
    // field positions
    localparam int         STAT1_FULL   = 5;
    localparam int         STAT1_FRAME  = 1;
    localparam int         STAT2_BREAK  = 1;
    localparam int         STAT2_RXPROG = 0;
    localparam int         CTRL3_NINTH  = 7;
    localparam int         CTRL3_NINE   = 4;
    localparam int         RATE_PS_LSB  = 4;
    // reset values
    localparam logic [1:0] PS_RESET     = 2'h0;
    localparam logic [2:0] RD_RESET     = 3'h0;
    // prescale divisors
    localparam logic [3:0] PD_00        = 4'h1;
    localparam logic [3:0] PD_01        = 4'h3;
    localparam logic [3:0] PD_10        = 4'h4;
    localparam logic [3:0] PD_11        = 4'hD;
    // timing
    localparam int         CRYSTAL_DIV  = 64;
    localparam int         SLOTS_BIT    = 16;
    localparam int         CLK_PER_SLOT = CRYSTAL_DIV / SLOTS_BIT;
    localparam logic [3:0] FIRST_SLOT   = 4'h1;
    localparam logic [3:0] MID_SLOT     = 4'h8;
    localparam logic [3:0] BITS_8       = 4'h8;
    localparam logic [3:0] BITS_9       = 4'h9;
    localparam logic [7:0] IDLE_SLOTS_8 = 8'hA0;
    localparam logic [7:0] IDLE_SLOTS_9 = 8'hB0;
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_START,
        ST_DATA,
        ST_STOP
    } urx_state_e;
endpackage

// [rtl/urx_baud_gen.sv]
// baud divider giving sample-slot and bit ticks
`timescale 1ns/1ps
module urx_baud_gen #(
    parameter int CNT_W = 13
) (
    input  wire logic       clk,         // system clock
    input  wire logic       nrst,        // async reset, active low
    input  wire logic [1:0] prescaleSel, // prescale code
    input  wire logic [2:0] rateSel,     // power-of-two code
    output logic            slotTick,    // one pulse per sample slot
    output logic            bitTick      // one pulse per bit period
);
    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic [3:0]       slot;
        logic             tick;
        logic             bitT;
    } urx_bg_s;
    localparam urx_bg_s BG_RST = '0;

    urx_bg_s          bg_reg;
    urx_bg_s          bg_next;
    logic [3:0]       pd;
    logic [CNT_W-1:0] lim;

    // divisor decode and free-running count
    always_comb begin
        case (prescaleSel)
            2'h0:    pd = urx_pkg::PD_00;
            2'h1:    pd = urx_pkg::PD_01;
            2'h2:    pd = urx_pkg::PD_10;
            default: pd = urx_pkg::PD_11;
        endcase
        // slot = 4 clocks times both divisors, so a bit is 64x
        lim = ((CNT_W'(pd) * CNT_W'(urx_pkg::CLK_PER_SLOT))
              << rateSel) - CNT_W'(1);
        bg_next = bg_reg;
        bg_next.tick = 1'b0;
        bg_next.bitT = 1'b0;
        // >= so a smaller new setting never waits for a wrap
        if (bg_reg.cnt >= lim) begin
            bg_next.cnt  = '0;
            bg_next.tick = 1'b1;
            bg_next.slot = bg_reg.slot + 4'h1;
            bg_next.bitT = (bg_reg.slot == 4'hF);
        end else begin
            bg_next.cnt = bg_reg.cnt + CNT_W'(1);
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            bg_reg <= BG_RST;
        end else begin
            bg_reg <= bg_next;
        end
    end

    assign slotTick = bg_reg.tick;
    assign bitTick  = bg_reg.bitT;

    // helper: cycles since last tick, and setting changes
    logic [CNT_W-1:0] gapCnt;
    logic             selChg;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            gapCnt <= '1;
            selChg <= 1'b0;
        end else begin
            gapCnt <= slotTick ? '0 : gapCnt + CNT_W'(1);
            selChg <= slotTick ? 1'b0
                    : (selChg | ($past(prescaleSel) != prescaleSel)
                       | ($past(rateSel) != rateSel));
        end
    end

    slot_gap_a: assert property (
        @(posedge clk) disable iff (!nrst)
        slotTick && !selChg && $stable(prescaleSel) && $stable(rateSel)
        |-> gapCnt == lim)
        else $error("slot period differs from divisor");
    bit_slot_a: assert property (
        @(posedge clk) disable iff (!nrst)
        bitTick |-> slotTick ##1 !bitTick [*8])
        else $error("bit tick off slot grid");
endmodule

// [rtl/urx_top.sv]
// receiver status, data buffer and baud control behind Avalon-MM
//
// The implementer's own choice: the Avalon-MM slave port.
`timescale 1ns/1ps
module urx_top (
    input  wire logic        clk,             // 250 MHz system clock
    input  wire logic        nrst,            // async reset, active low
    input  wire logic [7:0]  avs_address,     // byte address
    input  wire logic        avs_read,        // read request
    input  wire logic        avs_write,       // write request
    input  wire logic [31:0] avs_writedata,   // write data
    input  wire logic [3:0]  avs_byteenable,  // lane 0 used
    output logic      [31:0] avs_readdata,    // read data
    output logic             avs_waitrequest, // low for one answer cycle
    input  wire logic        rxPin,           // serial receive pin
    output logic      [7:0]  txData,          // character to transmit
    output logic             txLoad,          // pulse on data write
    output logic             slotTick,        // sample-slot tick
    output logic             bitTick          // bit-rate tick
);
    typedef struct packed {
        logic                sync1;
        logic                sync2;
        urx_pkg::urx_state_e state;
        logic [3:0]          slot;
        logic [3:0]          bitIdx;
        logic [7:0]          idleCnt;
        logic                waitHigh;
        logic                brkArmed;
        logic                full;
        logic                frame;
        logic                brk;
        logic                rx_in_progress_flag;
        logic                seen1;
        logic                seen2;
        logic                nine;
        logic                ninth;
        logic [1:0]          ps;
        logic [2:0]          rd;
        logic                waitReq;
        logic                txLoad;
        logic [31:0]         rdData;
    } urx_ctl_s;

    typedef struct packed {
        urx_ctl_s   c;
        logic [8:0] shift;
        logic [7:0] rxData;
        logic [7:0] txHold;
    } urx_top_s;

    localparam urx_ctl_s CTL_RST = '{
        sync1:   1'b1,
        sync2:   1'b1,
        state:   urx_pkg::ST_IDLE,
        ps:      urx_pkg::PS_RESET,
        rd:      urx_pkg::RD_RESET,
        waitReq: 1'b1,
        default: '0
    };

    urx_top_s    t_reg;
    urx_top_s    t_next;
    logic        rxS;
    logic        req;
    logic        acc;
    logic        rdAcc;
    logic        wrAcc;
    logic        brkEvt;
    logic        falseStart;
    logic        idleEvt;
    logic [3:0]  slotInc;
    logic [3:0]  nbits;
    logic [7:0]  idleLim;
    logic [8:0]  shIn;
    logic [31:0] rdMux;

    // one divider feeds receiver slots and transmitter bit tick
    urx_baud_gen u_baud (
        .clk         (clk),
        .nrst        (nrst),
        .prescaleSel (t_reg.c.ps),
        .rateSel     (t_reg.c.rd),
        .slotTick    (slotTick),
        .bitTick     (bitTick)
    );

    // next state: bus first, receiver after so its sets win
    always_comb begin
        t_next = t_reg;
        t_next.c.txLoad = 1'b0;
        t_next.c.sync1 = rxPin;
        t_next.c.sync2 = t_reg.c.sync1;
        rxS = t_reg.c.sync2;
        req = avs_read | avs_write;
        acc = req & ~t_reg.c.waitReq;
        rdAcc = acc & avs_read;
        wrAcc = acc & avs_write & avs_byteenable[0];
        brkEvt = 1'b0;
        falseStart = 1'b0;
        idleEvt = 1'b0;
        nbits = t_reg.c.nine ? urx_pkg::BITS_9 : urx_pkg::BITS_8;
        idleLim = t_reg.c.nine ? urx_pkg::IDLE_SLOTS_9
                               : urx_pkg::IDLE_SLOTS_8;
        slotInc = t_reg.c.slot + 4'h1;
        shIn = {rxS, t_reg.shift[8:1]};

        // read-back mux, unmapped addresses read zero
        rdMux = '0;
        case (avs_address)
            urx_pkg::OFS_STAT1: begin
                rdMux[urx_pkg::STAT1_FULL]  = t_reg.c.full;
                rdMux[urx_pkg::STAT1_FRAME] = t_reg.c.frame;
            end
            urx_pkg::OFS_STAT2: begin
                rdMux[urx_pkg::STAT2_BREAK]  = t_reg.c.brk;
                rdMux[urx_pkg::STAT2_RXPROG] = t_reg.c.rx_in_progress_flag;
            end
            urx_pkg::OFS_DATA: begin
                rdMux[7:0] = t_reg.rxData;
            end
            urx_pkg::OFS_RATE: begin
                rdMux[urx_pkg::RATE_PS_LSB +: 2] = t_reg.c.ps;
                rdMux[2:0] = t_reg.c.rd;
            end
            urx_pkg::OFS_CTRL3: begin
                rdMux[urx_pkg::CTRL3_NINTH] = t_reg.c.ninth;
                rdMux[urx_pkg::CTRL3_NINE]  = t_reg.c.nine;
            end
            default: begin
                rdMux = '0;
            end
        endcase

        // one wait state: answer is registered while master holds
        t_next.c.waitReq = 1'b1;
        if (req && t_reg.c.waitReq) begin
            t_next.c.waitReq = 1'b0;
            t_next.c.rdData = rdMux;
        end

        // read side effects use the value the master actually saw
        if (rdAcc && avs_address == urx_pkg::OFS_STAT1) begin
            t_next.c.seen1 = t_reg.c.rdData[urx_pkg::STAT1_FULL]
                           | t_reg.c.rdData[urx_pkg::STAT1_FRAME];
        end
        if (rdAcc && avs_address == urx_pkg::OFS_STAT2) begin
            t_next.c.seen2 = t_reg.c.rdData[urx_pkg::STAT2_BREAK];
        end
        if (rdAcc && avs_address == urx_pkg::OFS_DATA) begin
            if (t_reg.c.seen1) begin
                t_next.c.full = 1'b0;
                t_next.c.frame = 1'b0;
            end
            if (t_reg.c.seen2) begin
                t_next.c.brk = 1'b0;
            end
            t_next.c.seen1 = 1'b0;
            t_next.c.seen2 = 1'b0;
        end

        // writes; status registers ignore writes, no irq lines exist
        if (wrAcc) begin
            case (avs_address)
                urx_pkg::OFS_DATA: begin
                    t_next.txHold = avs_writedata[7:0];
                    t_next.c.txLoad = 1'b1;
                end
                urx_pkg::OFS_RATE: begin
                    t_next.c.ps =
                        avs_writedata[urx_pkg::RATE_PS_LSB +: 2];
                    t_next.c.rd = avs_writedata[2:0];
                end
                urx_pkg::OFS_CTRL3: begin
                    t_next.c.nine = avs_writedata[urx_pkg::CTRL3_NINE];
                end
                default: begin
                    t_next.c.txLoad = 1'b0;
                end
            endcase
        end

        // receiver, one step per sample slot
        if (slotTick) begin
            case (t_reg.c.state)
                urx_pkg::ST_IDLE: begin
                    if (rxS) begin
                        t_next.c.waitHigh = 1'b0;
                        t_next.c.brkArmed = 1'b1;
                        if (t_reg.c.idleCnt != idleLim) begin
                            t_next.c.idleCnt = t_reg.c.idleCnt + 8'h01;
                        end
                        if (t_reg.c.idleCnt + 8'h01 == idleLim) begin
                            idleEvt = 1'b1;
                            t_next.c.rx_in_progress_flag = 1'b0;
                        end
                    end else begin
                        t_next.c.idleCnt = '0;
                    end
                    // a low line left by a framing error is no start
                    if (!rxS && !t_reg.c.waitHigh) begin
                        t_next.c.state = urx_pkg::ST_START;
                        t_next.c.slot = urx_pkg::FIRST_SLOT;
                        t_next.c.rx_in_progress_flag = 1'b1;
                    end
                end
                urx_pkg::ST_START: begin
                    t_next.c.slot = slotInc;
                    if (slotInc == urx_pkg::MID_SLOT) begin
                        if (rxS) begin
                            falseStart = 1'b1;
                            t_next.c.rx_in_progress_flag = 1'b0;
                            t_next.c.state = urx_pkg::ST_IDLE;
                        end else begin
                            t_next.c.bitIdx = '0;
                            t_next.c.state = urx_pkg::ST_DATA;
                        end
                    end
                end
                urx_pkg::ST_DATA: begin
                    t_next.c.slot = slotInc;
                    if (slotInc == urx_pkg::MID_SLOT) begin
                        t_next.shift = shIn;
                        t_next.c.bitIdx = t_reg.c.bitIdx + 4'h1;
                        if (t_reg.c.bitIdx + 4'h1 == nbits) begin
                            t_next.c.state = urx_pkg::ST_STOP;
                            // eight-bit frames end one place short
                            if (!t_reg.c.nine) begin
                                t_next.shift = {1'b0, shIn[8:1]};
                            end
                        end
                    end
                end
                urx_pkg::ST_STOP: begin
                    t_next.c.slot = slotInc;
                    if (slotInc == urx_pkg::MID_SLOT) begin
                        t_next.c.state = urx_pkg::ST_IDLE;
                        t_next.c.idleCnt = '0;
                        t_next.c.full = 1'b1;
                        t_next.rxData = t_reg.shift[7:0];
                        if (t_reg.c.nine) begin
                            t_next.c.ninth = t_reg.shift[8];
                        end
                        if (!rxS) begin
                            t_next.c.frame = 1'b1;
                            t_next.c.waitHigh = 1'b1;
                            if (t_reg.shift == '0 && t_reg.c.brkArmed) begin
                                brkEvt = 1'b1;
                                t_next.c.brk = 1'b1;
                                t_next.c.brkArmed = 1'b0;
                                if (t_reg.c.nine) begin
                                    t_next.c.ninth = 1'b0;
                                end
                            end
                        end
                    end
                end
                default: begin
                    t_next.c.state = urx_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // data holding registers are left out of reset on purpose
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            t_reg.c <= CTL_RST;
        end else begin
            t_reg <= t_next;
        end
    end

    assign avs_readdata    = t_reg.c.rdData;
    assign avs_waitrequest = t_reg.c.waitReq;
    assign txData          = t_reg.txHold;
    assign txLoad          = t_reg.c.txLoad;

    brk_flags_a: assert property (
        @(posedge clk) disable iff (!nrst)
        brkEvt |=> t_reg.c.brk && t_reg.c.full && t_reg.c.frame)
        else $error("break did not set flags");
    brk_ninth_a: assert property (
        @(posedge clk) disable iff (!nrst)
        brkEvt && t_reg.c.nine |=> !t_reg.c.ninth)
        else $error("ninth bit kept after break");
    brk_clear_a: assert property (
        @(posedge clk) disable iff (!nrst)
        $fell(t_reg.c.brk) |-> $past(rdAcc) && $past(t_reg.c.seen2)
        && $past(avs_address) == urx_pkg::OFS_DATA)
        else $error("break cleared without sequence");
    brk_rearm_a: assert property (
        @(posedge clk) disable iff (!nrst)
        $rose(t_reg.c.brk) |-> $past(t_reg.c.brkArmed))
        else $error("break set while not rearmed");
    reset_state_a: assert property (
        @(posedge clk)
        !nrst |-> !t_reg.c.brk && t_reg.c.ps == urx_pkg::PS_RESET
        && t_reg.c.rd == urx_pkg::RD_RESET)
        else $error("reset left flag or rate set");
    rpf_start_a: assert property (
        @(posedge clk) disable iff (!nrst)
        t_reg.c.state == urx_pkg::ST_IDLE && slotTick && !rxS
        && !t_reg.c.waitHigh |=> t_reg.c.rx_in_progress_flag
        && t_reg.c.slot == urx_pkg::FIRST_SLOT)
        else $error("start search did not set flag");
    rpf_write_a: assert property (
        @(posedge clk) disable iff (!nrst)
        wrAcc && avs_address == urx_pkg::OFS_STAT2 && !slotTick
        |=> $stable(t_reg.c.rx_in_progress_flag))
        else $error("write changed in-progress flag");
    rpf_clear_a: assert property (
        @(posedge clk) disable iff (!nrst)
        $fell(t_reg.c.rx_in_progress_flag) |-> $past(falseStart) || $past(idleEvt))
        else $error("in-progress cleared without cause");
    data_read_a: assert property (
        @(posedge clk) disable iff (!nrst)
        req && t_reg.c.waitReq ##1 rdAcc
        && avs_address == urx_pkg::OFS_DATA
        |-> avs_readdata == {24'h000000, $past(t_reg.rxData)})
        else $error("data read mismatch");
    wait_pulse_a: assert property (
        @(posedge clk) disable iff (!nrst)
        !avs_waitrequest |=> avs_waitrequest)
        else $error("wait state low for more than a cycle");
    tx_load_a: assert property (
        @(posedge clk) disable iff (!nrst)
        wrAcc && avs_address == urx_pkg::OFS_DATA
        |=> txLoad && txData == $past(avs_writedata[7:0]))
        else $error("data write not passed to transmitter");
    rate_write_a: assert property (
        @(posedge clk) disable iff (!nrst)
        wrAcc && avs_address == urx_pkg::OFS_RATE
        |=> t_reg.c.ps == $past(avs_writedata[urx_pkg::RATE_PS_LSB +: 2])
        && t_reg.c.rd == $past(avs_writedata[2:0]))
        else $error("rate write not taken");

    brk_seen_c: cover property (
        @(posedge clk) disable iff (!nrst) brkEvt);
    false_start_c: cover property (
        @(posedge clk) disable iff (!nrst) falseStart);
    idle_seen_c: cover property (
        @(posedge clk) disable iff (!nrst) idleEvt);
    flag_clear_c: cover property (
        @(posedge clk) disable iff (!nrst) $fell(t_reg.c.full));
    brk_clear_c: cover property (
        @(posedge clk) disable iff (!nrst) $fell(t_reg.c.brk));
endmodule

// [verification/urx_remote_tx.sv]
// model of the remote serial transmitter driving the receive line
`timescale 1ns/1ps
module urx_remote_tx #(
    parameter int BIT_CLKS = 64 // clocks per bit at reset rate
) (
    input  wire logic clk,   // bench clock
    output logic      rxLine // receive line, idle high
);
    initial rxLine = 1'b1;
    // hold one level for n clocks; entered just after a clock edge
    task automatic drive(input logic lvl, input int n);
        rxLine <= lvl;
        repeat (n) @(posedge clk);
    endtask
    // start bit, data lsb first, one stop bit; line stays at stop level
    task automatic send(input logic [8:0] ch, input int nBits,
                        input logic stopLvl);
        drive(1'b0, BIT_CLKS);
        for (int i = 0; i < nBits; i++) begin
            drive(ch[i], BIT_CLKS);
        end
        drive(stopLvl, BIT_CLKS); // low stop with all-zero data makes a break frame
    endtask
endmodule

// [verification/test_urx_top.sv]
// self-checking bench of the receive status, data and baud block
`timescale 1ns/1ps
module test_urx_top;
    logic        clk = 1'b0;
    logic        nrst = 1'b1;
    logic [7:0]  avs_address = 8'h00;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h00000000;
    logic [3:0]  avs_byteenable = 4'hF;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        rxPin;
    logic [7:0]  txData;
    logic        txLoad;
    logic        slotTick;
    logic        bitTick;
    int          n_mismatch = 0;
    int          cmp_count = 0;
    logic [7:0]  lfsrState = 8'h0B;
    logic [31:0] q;
    logic [7:0]  ch;
    int          n;
    int          sc;
    int          nLoad = 0;

    urx_top dut (.clk(clk), .nrst(nrst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .rxPin(rxPin), .txData(txData), .txLoad(txLoad),
        .slotTick(slotTick), .bitTick(bitTick));
    urx_remote_tx remote (.clk(clk), .rxLine(rxPin));

    // 250 MHz clock
    always #2 clk = ~clk;

    // count load pulses mid-cycle, where the level has settled
    always @(negedge clk) nLoad += int'(txLoad === 1'b1);

    // eight-bit lfsr, seeded so every run repeats
    function automatic logic [7:0] rnd();
        lfsrState = {lfsrState[6:0], lfsrState[7] ^ lfsrState[5]
                     ^ lfsrState[4] ^ lfsrState[3]};
        return lfsrState;
    endfunction

    // expected clocks per bit from prescale and rate codes
    function automatic int bitClks(logic [1:0] ps, logic [2:0] rc);
        int pd;
        case (ps)
            2'h0: pd = 1;
            2'h1: pd = 3;
            2'h2: pd = 4;
            default: pd = 13;
        endcase
        return 64 * pd * (1 << rc);
    endfunction

    task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one transfer, held until waitrequest is sampled low
    // no limit here: a hung slave is ended by the watchdog
    task automatic bus(logic wr, logic [7:0] a, logic [7:0] d);
        avs_address   <= a;
        avs_write     <= wr;
        avs_read      <= !wr;
        avs_writedata <= {24'h000000, d};
        do begin
            @(posedge clk);
        end while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        @(posedge clk); // lets waitrequest rise before the next request
    endtask

    // read and compare the masked byte
    task automatic rdChk(logic [7:0] a, logic [7:0] m, logic [7:0] e,
                         string what);
        bus(1'b0, a, 8'h00);
        chk(what, {24'h000000, e & m}, q & {24'h000000, m});
    endtask

    // write a rate setting, then time a full bit after the change settles
    task automatic baud(logic [1:0] ps, logic [2:0] rc);
        logic [7:0] v;
        v = {2'h0, ps, 1'b0, rc};
        bus(1'b1, urx_pkg::OFS_RATE, v);
        rdChk(urx_pkg::OFS_RATE, 8'hFF, v, "rate");
        for (int k = 0; k < 2; k++) begin
            n = 0;
            sc = 0;
            do begin
                @(posedge clk);
                n++;
                sc += int'(slotTick === 1'b1);
            end while (bitTick !== 1'b1 && n < 20000);
        end
        chk("bit period", 32'(bitClks(ps, rc)), 32'(n));
        chk("slots per bit", 32'h00000010, 32'(sc));
    endtask

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        nrst <= 1'b0;
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        rdChk(urx_pkg::OFS_RATE, 8'hFF, 8'h00, "rate rst");
        rdChk(urx_pkg::OFS_STAT2, 8'hFF, 8'h00, "stat2 rst");
        rdChk(8'h04, 8'hFF, 8'h00, "unmapped");
        for (int p = 0; p < 4; p++) begin
            baud(2'(p), 3'(rnd() % 8'h02));
        end
        for (int r = 0; r < 8; r++) begin
            baud(2'h0, 3'(r));
        end
        // lane disabled: write is answered but ignored
        avs_byteenable <= 4'h0;
        bus(1'b1, urx_pkg::OFS_RATE, 8'h35);
        avs_byteenable <= 4'hF;
        rdChk(urx_pkg::OFS_RATE, 8'hFF, 8'h07, "be ignored");
        bus(1'b1, urx_pkg::OFS_RATE, 8'h00);
        // random characters, checked for progress, data and idle
        for (int c = 0; c < 3; c++) begin
            ch = rnd();
            n = nLoad;
            bus(1'b1, urx_pkg::OFS_DATA, ch);
            chk("txData", {24'h000000, ch}, {24'h000000, txData});
            ch = rnd();
            fork
                remote.send({1'b0, ch}, 8, 1'b1);
                begin
                    repeat (100) @(posedge clk);
                    rdChk(urx_pkg::OFS_STAT2, 8'h01, 8'h01, "busy");
                end
            join
            chk("txLoad", 32'(n + 1), 32'(nLoad));
            rdChk(urx_pkg::OFS_STAT1, 8'h22, 8'h20, "full");
            rdChk(urx_pkg::OFS_DATA, 8'hFF, ch, "rx data");
            repeat (800) @(posedge clk);
            rdChk(urx_pkg::OFS_STAT2, 8'h01, 8'h00, "idle");
        end
        // short low glitch is a false start
        remote.drive(1'b0, 16);
        rdChk(urx_pkg::OFS_STAT2, 8'h01, 8'h01, "glitch busy");
        remote.drive(1'b1, 100);
        rdChk(urx_pkg::OFS_STAT2, 8'h01, 8'h00, "false start");
        // break, clear sequence, then line held low
        remote.send(9'h000, 8, 1'b0);
        rdChk(urx_pkg::OFS_STAT1, 8'h22, 8'h22, "brk stat1");
        rdChk(urx_pkg::OFS_STAT2, 8'h02, 8'h02, "brk set");
        rdChk(urx_pkg::OFS_DATA, 8'hFF, 8'h00, "brk data");
        rdChk(urx_pkg::OFS_STAT2, 8'h02, 8'h00, "brk clr");
        repeat (700) @(posedge clk);
        rdChk(urx_pkg::OFS_STAT2, 8'h02, 8'h00, "no rearm");
        remote.drive(1'b1, 200);
        remote.send(9'h000, 8, 1'b0);
        // data read without a flagged status read leaves break set
        rdChk(urx_pkg::OFS_DATA, 8'hFF, 8'h00, "brk data2");
        rdChk(urx_pkg::OFS_STAT2, 8'h02, 8'h02, "brk kept");
        // a nonzero character, so the reset check can tell kept from zero
        remote.drive(1'b1, 200);
        ch = rnd();
        remote.send({1'b0, ch}, 8, 1'b1);
        remote.drive(1'b1, 700);
        // reset mid-run: flags and rate clear, buffers keep contents
        bus(1'b1, urx_pkg::OFS_DATA, ch);
        bus(1'b1, urx_pkg::OFS_RATE, 8'h13);
        rdChk(urx_pkg::OFS_STAT2, 8'h01, 8'h00, "poll idle");
        nrst <= 1'b0;
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        rdChk(urx_pkg::OFS_STAT2, 8'h02, 8'h00, "brk rst");
        rdChk(urx_pkg::OFS_RATE, 8'hFF, 8'h00, "rate rst2");
        chk("tx kept", {24'h000000, ch}, {24'h000000, txData});
        rdChk(urx_pkg::OFS_DATA, 8'hFF, ch, "rx kept");
        bus(1'b1, urx_pkg::OFS_STAT2, 8'hFF);
        rdChk(urx_pkg::OFS_STAT2, 8'hFF, 8'h00, "stat2 ro");
        // nine-bit mode: ninth bit stored, then cleared by a break
        bus(1'b1, urx_pkg::OFS_CTRL3, 8'h10);
        ch = rnd();
        remote.send({1'b1, ch}, 9, 1'b1);
        rdChk(urx_pkg::OFS_CTRL3, 8'h90, 8'h90, "ninth set");
        rdChk(urx_pkg::OFS_DATA, 8'hFF, ch, "rx9 data");
        remote.drive(1'b1, 200);
        remote.send(9'h000, 9, 1'b0);
        remote.drive(1'b1, 200);
        rdChk(urx_pkg::OFS_CTRL3, 8'h90, 8'h10, "ninth clr");
        rdChk(urx_pkg::OFS_STAT2, 8'h02, 8'h02, "brk9 set");
        finish_test();
    end

    // watchdog well beyond the expected run of about 50k cycles
    initial begin
        repeat (100000) @(posedge clk);
        n_mismatch++;
        finish_test();
    end
endmodule
